// ### common/sisel_defines.svh
// Register indices, field positions and reset values of the
// interrupt-enable and slave-select block.
// Assumes a word-indexed register port; index times four gives bytes.
`ifndef SISEL_DEFINES_SVH
`define SISEL_DEFINES_SVH

// Word indices of the register file
`define SISEL_IDX_W 3
`define SISEL_IDX_STATUS 3'h2
`define SISEL_IDX_CONTROL 3'h3
`define SISEL_IDX_SSMASK 3'h5

// Status bit positions
`define SISEL_ST_RX_OVERRUN_BIT 3
`define SISEL_ST_TX_OVERRUN_BIT 4
`define SISEL_ST_SHIFT_EMPTY_BIT 5
`define SISEL_ST_TX_EMPTY_BIT 6
`define SISEL_ST_RX_FULL_BIT 7
`define SISEL_ST_ANY_ERROR_BIT 8

// Control bit positions
`define SISEL_CTL_RX_OVR_EN_BIT 3
`define SISEL_CTL_TX_OVR_EN_BIT 4
`define SISEL_CTL_TX_EMPTY_EN_BIT 6
`define SISEL_CTL_RX_FULL_EN_BIT 7
`define SISEL_CTL_ANY_ERR_EN_BIT 8
`define SISEL_CTL_FORCE_SEL_BIT 10

// Reset values
`define SISEL_CTRL_RESET 6'h00
`define SISEL_MASK_RESET 32'h0000_0001
`define SISEL_WORD_ZERO 32'h0000_0000
`define SISEL_WORD_ONES 32'hFFFF_FFFF
`define SISEL_REG_W 32

`endif

// ### common/sisel_pkg.sv
// Types shared by the interrupt-enable and slave-select block.
// Assumes sisel_defines.svh is on the include path.
`include "sisel_defines.svh"

package sisel_pkg;

    // Control bits that steer logic; other control bits do not exist
    typedef struct packed {
        logic any_error_irq_enable;
        logic rx_full_irq_enable;
        logic tx_empty_irq_enable;
        logic tx_overrun_irq_enable;
        logic rx_overrun_irq_enable;
        logic force_select_output;
    } sisel_ctrl_t;

    // One register-port request, single cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`SISEL_IDX_W-1:0] addr;
        logic [`SISEL_REG_W-1:0] wdata;
    } sisel_bus_req_t;

    // Whole state of the main module
    typedef struct packed {
        sisel_ctrl_t ctrl;
        logic [`SISEL_REG_W-1:0] mask;
        logic [`SISEL_REG_W-1:0] rdata;
        logic rvalid;
        logic irq;
        logic [`SISEL_REG_W-1:0] ss_n;
    } sisel_state_t;

    // State of one sticky flag
    typedef struct packed {
        logic flag;
    } sisel_flag_state_t;

endpackage : sisel_pkg

// ### hdl/sisel_sticky_flag.sv
// Sticky error flag: set by a one-cycle event, cleared by software.
// Assumes set and clear come from logic on clock_i.
module sisel_sticky_flag
    import sisel_pkg::*;
(
    input logic clock_i,
    input logic sys_rst_i,
    input logic set_i,
    input logic clear_i,
    output logic flag_o
);

    sisel_flag_state_t st_q;
    sisel_flag_state_t st_d;

    ////////////////////////////////////////////////////////////////////
    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        st_d = st_q;
        if (set_i) begin
            st_d.flag = 1'b1;
        end else if (clear_i) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    flag_set_wins_a: assert property (set_i |=> flag_o)
        else $error("flag lost an event");
    flag_clear_a: assert property (clear_i && !set_i |=> !flag_o)
        else $error("flag not cleared by status write");
    flag_hold_a: assert property (!set_i && !clear_i |=> $stable(flag_o))
        else $error("flag changed without cause");

endmodule : sisel_sticky_flag

// ### hdl/sisel_top.sv
// Interrupt-enable and slave-select part of an SPI master core.
// Assumes the shift engine, holding registers and flag sources live
// outside, on clock_i, and drive the event and level inputs below.
// Function
// - Interrupt asserts whenever any status flag other than shift empty and its enable are both one.
// - Control bit 3 lets receive overrun raise the interrupt.
// - Control bit 4 lets transmit overrun raise the interrupt.
// - Control bit 6 lets transmit holding empty raise the interrupt.
// - Control bit 7 lets receive holding full raise the interrupt.
// - Control bit 8 lets the combined error flag raise the interrupt.
// - Control bit 10 keeps masked selects driven regardless of shifting.
// - Forced selects are exactly the lines set in the mask.
// - Reset clears all control bits: no interrupts, no selects.
// - During a shift only masked selects assert, all others stay inactive.
// - Mask register exists only in master configuration.
// - Mask holds one bit per select output; count is a parameter.
// - Several mask bits set assert all their selects together.
// - Reset loads mask bit 0 as one, higher bits zero.
// - Combined error flag equals receive overrun OR transmit overrun.
// - Reading control returns contents without altering any bit.
// - Select lines are active low.
module sisel_top
    import sisel_pkg::*;
#(
    parameter int NUM_SS = 8,
    parameter bit IS_MASTER = 1'b1
) (
    input logic clock_i,
    input logic sys_rst_i,
    input sisel_bus_req_t bus_req_i,
    output logic [`SISEL_REG_W-1:0] bus_rdata_o,
    output logic bus_rvalid_o,
    input logic rx_overrun_evt_i,
    input logic tx_overrun_evt_i,
    input logic tx_holding_empty_i,
    input logic rx_holding_full_i,
    input logic shift_empty_i,
    input logic transfer_active_i,
    output logic irq_o,
    output logic [NUM_SS-1:0] ss_n_o
);

    // Mask bits that correspond to real select outputs
    localparam logic [`SISEL_REG_W-1:0] SS_USED =
        `SISEL_WORD_ONES >> (`SISEL_REG_W - NUM_SS);

    sisel_state_t st_q;
    sisel_state_t st_d;

    logic receive_overrun_flag;
    logic transmit_overrun_flag;
    logic any_error_flag;
    logic tx_holding_empty_flag;
    logic rx_holding_full_flag;
    logic status_wr;
    logic [`SISEL_REG_W-1:0] status_word;
    logic [`SISEL_REG_W-1:0] control_word;
    logic [`SISEL_REG_W-1:0] mask_word;
    logic [`SISEL_REG_W-1:0] read_word;
    logic irq_raw;
    logic sel_active;

    ////////////////////////////////////////////////////////////////////
    // Sticky overrun flags, cleared by any status write
    assign status_wr = bus_req_i.wr &&
        (bus_req_i.addr == `SISEL_IDX_STATUS);

    sisel_sticky_flag u_rx_overrun (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .set_i(rx_overrun_evt_i),
        .clear_i(status_wr),
        .flag_o(receive_overrun_flag)
    );

    sisel_sticky_flag u_tx_overrun (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .set_i(tx_overrun_evt_i),
        .clear_i(status_wr),
        .flag_o(transmit_overrun_flag)
    );

    // Combined error is derived, so it can never disagree with its parts
    assign any_error_flag = receive_overrun_flag |
        transmit_overrun_flag;
    assign tx_holding_empty_flag = tx_holding_empty_i;
    assign rx_holding_full_flag = rx_holding_full_i;

    ////////////////////////////////////////////////////////////////////
    // Read words; undefined bits read as zero
    always_comb begin
        status_word = `SISEL_WORD_ZERO;
        status_word[`SISEL_ST_RX_OVERRUN_BIT] = receive_overrun_flag;
        status_word[`SISEL_ST_TX_OVERRUN_BIT] = transmit_overrun_flag;
        status_word[`SISEL_ST_SHIFT_EMPTY_BIT] = shift_empty_i;
        status_word[`SISEL_ST_TX_EMPTY_BIT] = tx_holding_empty_flag;
        status_word[`SISEL_ST_RX_FULL_BIT] = rx_holding_full_flag;
        status_word[`SISEL_ST_ANY_ERROR_BIT] = any_error_flag;
        control_word = `SISEL_WORD_ZERO;
        control_word[`SISEL_CTL_RX_OVR_EN_BIT] =
            st_q.ctrl.rx_overrun_irq_enable;
        control_word[`SISEL_CTL_TX_OVR_EN_BIT] =
            st_q.ctrl.tx_overrun_irq_enable;
        control_word[`SISEL_CTL_TX_EMPTY_EN_BIT] =
            st_q.ctrl.tx_empty_irq_enable;
        control_word[`SISEL_CTL_RX_FULL_EN_BIT] =
            st_q.ctrl.rx_full_irq_enable;
        control_word[`SISEL_CTL_ANY_ERR_EN_BIT] =
            st_q.ctrl.any_error_irq_enable;
        control_word[`SISEL_CTL_FORCE_SEL_BIT] =
            st_q.ctrl.force_select_output;
        // An absent mask register reads as zero
        mask_word = IS_MASTER ? st_q.mask : `SISEL_WORD_ZERO;
        if (bus_req_i.addr == `SISEL_IDX_STATUS) begin
            read_word = status_word;
        end else if (bus_req_i.addr == `SISEL_IDX_CONTROL) begin
            read_word = control_word;
        end else if (bus_req_i.addr == `SISEL_IDX_SSMASK) begin
            read_word = mask_word;
        end else begin
            read_word = `SISEL_WORD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt sources gated by their enables
    assign irq_raw =
        (st_q.ctrl.rx_overrun_irq_enable & receive_overrun_flag) |
        (st_q.ctrl.tx_overrun_irq_enable & transmit_overrun_flag) |
        (st_q.ctrl.tx_empty_irq_enable & tx_holding_empty_flag) |
        (st_q.ctrl.rx_full_irq_enable & rx_holding_full_flag) |
        (st_q.ctrl.any_error_irq_enable & any_error_flag);

    // Selects drive during a shift or while forced by software
    assign sel_active = st_q.ctrl.force_select_output |
        transfer_active_i;

    ////////////////////////////////////////////////////////////////////
    // Next state: register writes, read capture, registered outputs
    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        if (bus_req_i.wr) begin
            if (bus_req_i.addr == `SISEL_IDX_CONTROL) begin
                // Only the six defined bits are stored
                st_d.ctrl.rx_overrun_irq_enable =
                    bus_req_i.wdata[`SISEL_CTL_RX_OVR_EN_BIT];
                st_d.ctrl.tx_overrun_irq_enable =
                    bus_req_i.wdata[`SISEL_CTL_TX_OVR_EN_BIT];
                st_d.ctrl.tx_empty_irq_enable =
                    bus_req_i.wdata[`SISEL_CTL_TX_EMPTY_EN_BIT];
                st_d.ctrl.rx_full_irq_enable =
                    bus_req_i.wdata[`SISEL_CTL_RX_FULL_EN_BIT];
                st_d.ctrl.any_error_irq_enable =
                    bus_req_i.wdata[`SISEL_CTL_ANY_ERR_EN_BIT];
                st_d.ctrl.force_select_output =
                    bus_req_i.wdata[`SISEL_CTL_FORCE_SEL_BIT];
            end else if (bus_req_i.addr == `SISEL_IDX_SSMASK) begin
                // Slave builds have no mask, so writes vanish
                if (IS_MASTER) begin
                    st_d.mask = bus_req_i.wdata & SS_USED;
                end
            end
        end
        // Read has no side effect on any stored bit
        if (bus_req_i.rd) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = read_word;
        end
        st_d.irq = irq_raw;
        // Active low: a selected slave sees its line driven low
        if (IS_MASTER && sel_active) begin
            st_d.ss_n = ~(st_q.mask & SS_USED);
        end else begin
            st_d.ss_n = `SISEL_WORD_ONES;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; reset leaves selects idle and interrupts off
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q.ctrl <= `SISEL_CTRL_RESET;
            st_q.mask <= `SISEL_MASK_RESET;
            st_q.rdata <= `SISEL_WORD_ZERO;
            st_q.rvalid <= 1'b0;
            st_q.irq <= 1'b0;
            st_q.ss_n <= `SISEL_WORD_ONES;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata_o = st_q.rdata;
    assign bus_rvalid_o = st_q.rvalid;
    assign irq_o = st_q.irq;
    assign ss_n_o = st_q.ss_n[NUM_SS-1:0];

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    logic [NUM_SS-1:0] used_mask;
    logic ctrl_rd_only;
    logic rst_seen_q;
    assign used_mask = st_q.mask[NUM_SS-1:0];
    assign ctrl_rd_only = bus_req_i.rd && !bus_req_i.wr;

    // Helper: high during reset and on the first cycle after reset release
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_seen_q <= 1'b1;
        end else begin
            rst_seen_q <= 1'b0;
        end
    end

    sequence s_forced;
        st_q.ctrl.force_select_output && IS_MASTER;
    endsequence

    sequence s_idle_sel;
        !st_q.ctrl.force_select_output && !transfer_active_i;
    endsequence

    sequence s_shift_sel;
        transfer_active_i && IS_MASTER;
    endsequence

    irq_cause_a: assert property (irq_o |-> $past(irq_raw))
        else $error("interrupt without an enabled source");
    irq_quiet_a: assert property (!irq_raw |=> !irq_o)
        else $error("interrupt with no source");
    rx_ovr_irq_a: assert property (
        st_q.ctrl.rx_overrun_irq_enable && receive_overrun_flag
        |=> irq_o)
        else $error("receive overrun did not interrupt");
    tx_ovr_irq_a: assert property (
        st_q.ctrl.tx_overrun_irq_enable && transmit_overrun_flag
        |=> irq_o)
        else $error("transmit overrun did not interrupt");
    tx_empty_irq_a: assert property (
        st_q.ctrl.tx_empty_irq_enable && tx_holding_empty_i
        |=> irq_o)
        else $error("transmit empty did not interrupt");
    rx_full_irq_a: assert property (
        st_q.ctrl.rx_full_irq_enable && rx_holding_full_i
        |=> irq_o)
        else $error("receive full did not interrupt");
    err_irq_a: assert property (
        st_q.ctrl.any_error_irq_enable &&
        (receive_overrun_flag || transmit_overrun_flag)
        |=> irq_o)
        else $error("error flag did not interrupt");
    force_sel_a: assert property (s_forced |=>
        ss_n_o == ~$past(used_mask))
        else $error("forced selects do not follow mask");
    force_hold_a: assert property (
        s_forced ##1 s_forced ##1 s_forced |-> ss_n_o == ~$past(used_mask))
        else $error("forced selects dropped between words");
    shift_sel_a: assert property (s_shift_sel |=>
        ss_n_o == ~$past(used_mask))
        else $error("shift selects wrong lines");
    idle_sel_a: assert property (s_idle_sel |=> &ss_n_o)
        else $error("select asserted while idle");
    slave_nosel_a: assert property (!IS_MASTER |-> &ss_n_o)
        else $error("slave build drove a select");
    reset_state_a: assert property (rst_seen_q |->
        !irq_o && (&ss_n_o) && (st_q.ctrl == `SISEL_CTRL_RESET))
        else $error("control not cleared by reset");
    reset_mask_a: assert property (rst_seen_q |->
        st_q.mask == `SISEL_MASK_RESET)
        else $error("mask reset value wrong");
    err_bit_a: assert property (
        bus_req_i.rd && bus_req_i.addr == `SISEL_IDX_STATUS |=>
        bus_rdata_o[`SISEL_ST_ANY_ERROR_BIT] ==
        (bus_rdata_o[`SISEL_ST_RX_OVERRUN_BIT] |
         bus_rdata_o[`SISEL_ST_TX_OVERRUN_BIT]))
        else $error("combined error bit mismatch");
    status_clr_a: assert property (
        status_wr && !rx_overrun_evt_i && !tx_overrun_evt_i |=>
        !any_error_flag)
        else $error("status write left an error flag");
    ctrl_read_a: assert property (
        ctrl_rd_only && bus_req_i.addr == `SISEL_IDX_CONTROL |=>
        $stable(st_q.ctrl))
        else $error("control read altered control");
    ctrl_other_a: assert property (
        bus_req_i.wr && bus_req_i.addr == `SISEL_IDX_CONTROL |=>
        control_word == ($past(bus_req_i.wdata) & (
            (`SISEL_REG_W'(1) << `SISEL_CTL_RX_OVR_EN_BIT) |
            (`SISEL_REG_W'(1) << `SISEL_CTL_TX_OVR_EN_BIT) |
            (`SISEL_REG_W'(1) << `SISEL_CTL_TX_EMPTY_EN_BIT) |
            (`SISEL_REG_W'(1) << `SISEL_CTL_RX_FULL_EN_BIT) |
            (`SISEL_REG_W'(1) << `SISEL_CTL_ANY_ERR_EN_BIT) |
            (`SISEL_REG_W'(1) << `SISEL_CTL_FORCE_SEL_BIT))))
        else $error("undefined control bit stored");
    mask_width_a: assert property (
        (st_q.mask & ~SS_USED) == `SISEL_WORD_ZERO)
        else $error("mask holds bits beyond select count");
    multi_sel_a: assert property (
        (s_forced and $countones(used_mask) > 1) |=>
        $countones(~ss_n_o) == $countones($past(used_mask)))
        else $error("multiple selects not asserted together");
    read_lat_a: assert property (bus_req_i.rd |=> bus_rvalid_o)
        else $error("read answer missing");

endmodule : sisel_top

// ### verification/sisel_slave_model.sv
// Behavioural bank of select-driven serial slaves on the far side.
// Assumes active-low selects driven by the block on clock_i.
module sisel_slave_model #(
    parameter int NUM_SS = 8
) (
    input wire logic clock_i,
    input wire logic [NUM_SS-1:0] ss_n_i,
    output logic miso_o,
    output logic [5:0] selected_count_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Known start so the released line never shows an unknown
    logic miso_q = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // A slave counts as selected only while its line is low
    always_comb begin
        selected_count_o = 6'h00;
        for (int i = 0; i < NUM_SS; i++) begin
            if (ss_n_i[i] === 1'b0) begin
                selected_count_o = selected_count_o + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Only a lone selected slave drives data; with none or several the
    // line is treated as released and toggles, so no stale value lingers
    always_ff @(posedge clock_i) begin
        if (selected_count_o == 6'h01) begin
            miso_q <= 1'b1;
        end else begin
            miso_q <= ~miso_q;
        end
    end
    assign miso_o = miso_q;
endmodule : sisel_slave_model

// ### verification/sisel_top_tb.sv
// Self-checking bench for the interrupt-enable and slave-select block.
// Assumes sisel_defines.svh on the include path and a slave model.
`include "sisel_defines.svh"

module sisel_top_tb
    import sisel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NSS = 8;
    logic clock_i;
    logic sys_rst_i;
    sisel_bus_req_t bus_req;
    logic [31:0] rdata;
    logic rvalid;
    logic rx_evt;
    logic tx_evt;
    logic tx_empty;
    logic rx_full;
    logic shift_empty;
    logic xfer;
    logic irq;
    logic [NSS-1:0] ss_n;
    logic miso;
    logic [5:0] sel_cnt;
    logic [31:0] rd_word;
    int miscompares = 0;
    int checked = 0;

    sisel_top #(.NUM_SS(NSS), .IS_MASTER(1'b1)) dut_u (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_req_i(bus_req),
        .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
        .rx_overrun_evt_i(rx_evt), .tx_overrun_evt_i(tx_evt),
        .tx_holding_empty_i(tx_empty), .rx_holding_full_i(rx_full),
        .shift_empty_i(shift_empty), .transfer_active_i(xfer),
        .irq_o(irq), .ss_n_o(ss_n)
    );

    sisel_slave_model #(.NUM_SS(NSS)) slaves_u (
        .clock_i(clock_i), .ss_n_i(ss_n), .miso_o(miso),
        .selected_count_o(sel_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus_write(input logic [2:0] idx, input logic [31:0] d);
        @(posedge clock_i);
        bus_req <= '{rd: 1'b0, wr: 1'b1, addr: idx, wdata: d};
        @(posedge clock_i);
        bus_req <= '0;
    endtask : bus_write

    // Read data is taken with the one-cycle answer strobe
    task automatic read_check(input string what, input logic [2:0] idx,
                              input logic [31:0] exp);
        @(posedge clock_i);
        bus_req <= '{rd: 1'b1, wr: 1'b0, addr: idx, wdata: 32'h0000_0000};
        @(posedge clock_i);
        bus_req <= '0;
        #1;
        check("read answer strobe", 32'h0000_0001, {31'h0, rvalid});
        check(what, exp, rdata);
    endtask : read_check

    // Outputs lag their cause by up to two edges
    task automatic settle();
        repeat (3) @(posedge clock_i);
        #1;
    endtask : settle

    // Source k: 0 rx overrun, 1 tx overrun, 2 tx empty, 3 rx full, 4 error
    task automatic raise(input int k, input logic on);
        @(posedge clock_i);
        case (k)
            2: tx_empty <= on;
            3: rx_full <= on;
            default: begin
                if (on) begin
                    if (k == 1) tx_evt <= 1'b1;
                    else rx_evt <= 1'b1;
                    @(posedge clock_i);
                    tx_evt <= 1'b0;
                    rx_evt <= 1'b0;
                end
            end
        endcase
    endtask : raise

    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset_values();
        int unmapped[5];
        unmapped = '{0, 1, 4, 6, 7};
        check("irq after reset", 32'h0, {31'h0, irq});
        check("selects after reset", 32'hFF, {24'h0, ss_n});
        read_check("control reset", `SISEL_IDX_CONTROL, 32'h0);
        read_check("mask reset", `SISEL_IDX_SSMASK, 32'h1);
        read_check("status levels", `SISEL_IDX_STATUS, 32'h20);
        foreach (unmapped[i]) begin
            read_check("unmapped read", 3'(unmapped[i]), 32'h0);
        end
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_control_bits();
        bus_write(`SISEL_IDX_CONTROL, 32'hFFFF_FFFF);
        read_check("control implemented", `SISEL_IDX_CONTROL,
                   32'h0000_05D8);
        read_check("control reread", `SISEL_IDX_CONTROL,
                   32'h0000_05D8);
        settle();
        check("no source no irq", 32'h0, {31'h0, irq});
        check("forced default", 32'hFE, {24'h0, ss_n});
        check("lone slave drives", 32'h1, {31'h0, miso});
        bus_write(`SISEL_IDX_CONTROL, 32'h0000_0000);
        settle();
        check("force off", 32'hFF, {24'h0, ss_n});
        $display("test control_bits done");
    endtask : test_control_bits

    task automatic test_irq_sources();
        int en_bit[5];
        en_bit = '{3, 4, 6, 7, 8};
        for (int k = 0; k < 5; k++) begin
            bus_write(`SISEL_IDX_CONTROL, 32'h1 << en_bit[k]);
            settle();
            check("enable alone", 32'h0, {31'h0, irq});
            raise(k, 1'b1);
            settle();
            check("source fires", 32'h1, {31'h0, irq});
            bus_write(`SISEL_IDX_CONTROL, 32'h0);
            settle();
            check("source disabled", 32'h0, {31'h0, irq});
            raise(k, 1'b0);
            bus_write(`SISEL_IDX_STATUS, 32'h0);
        end
        $display("test irq_sources done");
    endtask : test_irq_sources

    task automatic test_status_flags();
        raise(0, 1'b1);
        raise(1, 1'b1);
        settle();
        read_check("both overruns", `SISEL_IDX_STATUS, 32'h138);
        bus_write(`SISEL_IDX_STATUS, 32'h0000_0000);
        read_check("status cleared", `SISEL_IDX_STATUS, 32'h20);
        raise(1, 1'b1);
        settle();
        read_check("tx overrun alone", `SISEL_IDX_STATUS, 32'h130);
        bus_write(`SISEL_IDX_STATUS, 32'hFFFF_FFFF);
        read_check("cleared again", `SISEL_IDX_STATUS, 32'h20);
        $display("test status_flags done");
    endtask : test_status_flags

    task automatic test_selects();
        bus_write(`SISEL_IDX_SSMASK, 32'hFFFF_FF62);
        read_check("mask width", `SISEL_IDX_SSMASK, 32'h62);
        settle();
        check("idle selects", 32'hFF, {24'h0, ss_n});
        @(posedge clock_i);
        xfer <= 1'b1;
        settle();
        check("shift selects", 32'h9D, {24'h0, ss_n});
        check("slaves selected", 32'h3, {26'h0, sel_cnt});
        @(posedge clock_i);
        xfer <= 1'b0;
        bus_write(`SISEL_IDX_CONTROL, 32'h0000_0400);
        settle();
        check("forced selects", 32'h9D, {24'h0, ss_n});
        @(posedge clock_i);
        xfer <= 1'b1;
        settle();
        @(posedge clock_i);
        xfer <= 1'b0;
        settle();
        check("held across words", 32'h9D, {24'h0, ss_n});
        bus_write(`SISEL_IDX_CONTROL, 32'h0);
        settle();
        check("release", 32'hFF, {24'h0, ss_n});
        $display("test selects done");
    endtask : test_selects

    task automatic test_reset_again();
        bus_write(`SISEL_IDX_SSMASK, 32'h0000_0081);
        bus_write(`SISEL_IDX_CONTROL, 32'h0000_05D8);
        tx_empty <= 1'b1;
        settle();
        check("forced before reset", 32'h7E, {24'h0, ss_n});
        check("irq before reset", 32'h1, {31'h0, irq});
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        settle();
        check("selects reset", 32'hFF, {24'h0, ss_n});
        check("irq reset", 32'h0, {31'h0, irq});
        read_check("control reset", `SISEL_IDX_CONTROL, 32'h0);
        read_check("mask reset", `SISEL_IDX_SSMASK, 32'h1);
        @(posedge clock_i);
        tx_empty <= 1'b0;
        $display("test reset_again done");
    endtask : test_reset_again

    ////////////////////////////////////////////////////////////////////
    // Main sequence; inputs start quiet with reset held 16 cycles
    initial begin
        sys_rst_i = 1'b1;
        bus_req = '0;
        rx_evt = 1'b0;
        tx_evt = 1'b0;
        tx_empty = 1'b0;
        rx_full = 1'b0;
        shift_empty = 1'b1;
        xfer = 1'b0;
        repeat (16) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        test_reset_values();
        test_control_bits();
        test_irq_sources();
        test_status_flags();
        test_selects();
        test_reset_again();
        finish_test();
    end

    // Whole run is well under 2000 cycles; cut a hang at 5000
    initial begin
        #100us;
        miscompares++;
        finish_test();
    end
endmodule : sisel_top_tb
